// ==== scmr_regs.sv ====
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
module scmr_regs
#(
	parameter int ADDR_W = 8
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic ir_function_on,
	output logic ir_polarity_sel,
	output logic ir_modulation_sel,
	output logic ir_data_source_sel,
	output logic ir_sw_data_bit,
	input wire logic ir_hw_data,
	output logic ir_data,
	output logic timer0_trigger_source,
	output logic timer1_trigger_source,
	output logic timer2_trigger_source,
	output logic timer3_trigger_source,
	output logic serial_b_pin_remap,
	output logic rtc_clock_source,
	output logic timer_pin_remap,
	output logic serial_a_pin_remap,
	input wire logic tmr0_cap_p1,
	input wire logic tmr0_cap_alt,
	output logic tmr0_capture,
	input wire logic tmr0_pwm,
	output logic tmr0_pwm_p1,
	output logic tmr0_pwm_alt,
	input wire logic sa_rx_hi,
	input wire logic sa_rx_lo,
	output logic sa_rx,
	input wire logic sa_tx,
	output logic sa_tx_hi,
	output logic sa_tx_lo
);

	// -----------------------------------------------------------------
	// elaboration checks
	// -----------------------------------------------------------------

	// the highest register sits at byte 18h, which needs five bits; the check sets the floor at eight
	if (ADDR_W < 8 || ADDR_W > 32)
	begin : g_bad_addr_w
		$error("scmr_regs: ADDR_W must be 8 to 32");
	end

	// -----------------------------------------------------------------
	// bus decode
	// -----------------------------------------------------------------

	logic sel_ir;
	logic sel_trg;
	logic sel_rmp;
	logic hit;
	logic acc;
	logic wr_en;
	logic wr_lo;
	logic wr_hi;

	// address compare against the byte addresses of the three registers
	assign sel_ir = (paddr == ADDR_W'(scmr_pkg::ADDR_IR)); // [RL13]
	assign sel_trg = (paddr == ADDR_W'(scmr_pkg::ADDR_TRG)); // [RL13]
	assign sel_rmp = (paddr == ADDR_W'(scmr_pkg::ADDR_RMP)); // [RL13]
	assign hit = sel_ir | sel_trg | sel_rmp;

	// zero wait states: every access completes in its first access cycle
	assign acc = psel & penable;
	assign pready = 1'b1;
	assign pslverr = acc & ~hit;

	// byte lanes 0 and 1 carry the sixteen register bits
	assign wr_en = acc & pwrite & hit;
	assign wr_lo = wr_en & pstrb[0]; // [RL14]
	assign wr_hi = wr_en & pstrb[1]; // [RL14]

	// -----------------------------------------------------------------
	// infrared control register
	// -----------------------------------------------------------------

	logic ir_on_q;
	logic ir_pol_q;
	logic ir_mod_q;
	logic ir_src_q;
	logic ir_dat_q;

	// infrared function on/off
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ir_on_q <= scmr_pkg::RST_IR[scmr_pkg::IR_ON_BIT]; // [RL2] [RL13]
		end
		else if (sel_ir && wr_lo)
		begin
			ir_on_q <= pwdata[scmr_pkg::IR_ON_BIT]; // [RL2]
		end
	end

	// output polarity
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ir_pol_q <= scmr_pkg::RST_IR[scmr_pkg::IR_POL_BIT]; // [RL13]
		end
		else if (sel_ir && wr_lo)
		begin
			ir_pol_q <= pwdata[scmr_pkg::IR_POL_BIT]; // [RL3]
		end
	end

	// modulation kind, consumed by the modulator outside
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ir_mod_q <= scmr_pkg::RST_IR[scmr_pkg::IR_MOD_BIT]; // [RL13]
		end
		else if (sel_ir && wr_lo)
		begin
			ir_mod_q <= pwdata[scmr_pkg::IR_MOD_BIT]; // [RL4]
		end
	end

	// data source select
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ir_src_q <= scmr_pkg::RST_IR[scmr_pkg::IR_SRC_BIT]; // [RL13]
		end
		else if (sel_ir && wr_lo)
		begin
			ir_src_q <= pwdata[scmr_pkg::IR_SRC_BIT]; // [RL5]
		end
	end

	// software data bit
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ir_dat_q <= scmr_pkg::RST_IR[scmr_pkg::IR_DAT_BIT]; // [RL13]
		end
		else if (sel_ir && wr_lo)
		begin
			ir_dat_q <= pwdata[scmr_pkg::IR_DAT_BIT]; // [RL6]
		end
	end

	// -----------------------------------------------------------------
	// trigger, serial B remap and rtc clock register
	// -----------------------------------------------------------------

	logic [scmr_pkg::TRG_CNT-1:0] trg_q;
	logic sb_rmp_q;
	logic rtc_sel_q;

	// one trigger select per timer; all live in the upper byte lane
	for (genvar i = 0; i < scmr_pkg::TRG_CNT; i++)
	begin : g_trg
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
			begin
				trg_q[i] <= scmr_pkg::RST_TRG[scmr_pkg::TRG_LSB+i]; // [RL13]
			end
			else if (sel_trg && wr_hi)
			begin
				trg_q[i] <= pwdata[scmr_pkg::TRG_LSB+i]; // [RL7]
			end
		end
	end

	// serial B pin remap
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sb_rmp_q <= scmr_pkg::RST_TRG[scmr_pkg::SB_RMP_BIT]; // [RL13]
		end
		else if (sel_trg && wr_hi)
		begin
			sb_rmp_q <= pwdata[scmr_pkg::SB_RMP_BIT]; // [RL8]
		end
	end

	// rtc clock source; glitch-free switching is the clock tree's job
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rtc_sel_q <= scmr_pkg::RST_TRG[scmr_pkg::RTC_SEL_BIT]; // [RL13]
		end
		else if (sel_trg && wr_hi)
		begin
			rtc_sel_q <= pwdata[scmr_pkg::RTC_SEL_BIT]; // [RL9]
		end
	end

	// -----------------------------------------------------------------
	// pin remap register
	// -----------------------------------------------------------------

	logic tmr_rmp_q;
	logic sa_rmp_q;

	// timer pin set
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tmr_rmp_q <= scmr_pkg::RST_RMP[scmr_pkg::TMR_RMP_BIT]; // [RL13]
		end
		else if (sel_rmp && wr_lo)
		begin
			tmr_rmp_q <= pwdata[scmr_pkg::TMR_RMP_BIT]; // [RL10]
		end
	end

	// serial A pin set
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sa_rmp_q <= scmr_pkg::RST_RMP[scmr_pkg::SA_RMP_BIT]; // [RL13]
		end
		else if (sel_rmp && wr_lo)
		begin
			sa_rmp_q <= pwdata[scmr_pkg::SA_RMP_BIT]; // [RL11]
		end
	end

	// -----------------------------------------------------------------
	// read back
	// -----------------------------------------------------------------

	logic [15:0] ir_word;
	logic [15:0] trg_word;
	logic [15:0] rmp_word;
	logic [31:0] prdata_d;
	logic [31:0] prdata_q;

	// assemble words; bits with no flop behind them read zero
	always_comb
	begin
		ir_word = 16'h0000; // [RL1]
		ir_word[scmr_pkg::IR_ON_BIT] = ir_on_q;
		ir_word[scmr_pkg::IR_POL_BIT] = ir_pol_q;
		ir_word[scmr_pkg::IR_MOD_BIT] = ir_mod_q;
		ir_word[scmr_pkg::IR_SRC_BIT] = ir_src_q;
		ir_word[scmr_pkg::IR_DAT_BIT] = ir_dat_q;
		trg_word = 16'h0000; // [RL1]
		trg_word[scmr_pkg::TRG_LSB +: scmr_pkg::TRG_CNT] = trg_q;
		trg_word[scmr_pkg::SB_RMP_BIT] = sb_rmp_q;
		trg_word[scmr_pkg::RTC_SEL_BIT] = rtc_sel_q;
		rmp_word = 16'h0000; // [RL1]
		rmp_word[scmr_pkg::TMR_RMP_BIT] = tmr_rmp_q;
		rmp_word[scmr_pkg::SA_RMP_BIT] = sa_rmp_q;
	end

	// read mux; upper half of the bus and unmapped reads give zero
	always_comb
	begin
		prdata_d = 32'h0000_0000;
		if (psel && !penable && !pwrite)
		begin
			if (sel_ir)
			begin
				prdata_d = {16'h0000, ir_word};
			end
			else if (sel_trg)
			begin
				prdata_d = {16'h0000, trg_word};
			end
			else if (sel_rmp)
			begin
				prdata_d = {16'h0000, rmp_word};
			end
		end
		else if (acc)
		begin
			prdata_d = prdata_q;
		end
	end

	// read data is captured in setup so it leaves a flop in the access cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_q <= 32'h0000_0000;
		end
		else
		begin
			prdata_q <= prdata_d;
		end
	end

	assign prdata = prdata_q;

	// -----------------------------------------------------------------
	// outputs to other units
	// -----------------------------------------------------------------

	assign ir_function_on = ir_on_q; // [RL2]
	assign ir_polarity_sel = ir_pol_q; // [RL3]
	assign ir_modulation_sel = ir_mod_q; // [RL4]
	assign ir_data_source_sel = ir_src_q; // [RL5]
	assign ir_sw_data_bit = ir_dat_q; // [RL6]
	// timer 0 owns the top bit, so the trigger vector is handed out downward
	assign timer0_trigger_source = trg_q[3]; // [RL7]
	assign timer1_trigger_source = trg_q[2]; // [RL7]
	assign timer2_trigger_source = trg_q[1]; // [RL7]
	assign timer3_trigger_source = trg_q[0]; // [RL7]
	assign serial_b_pin_remap = sb_rmp_q; // [RL8]
	assign rtc_clock_source = rtc_sel_q; // [RL9]
	assign timer_pin_remap = tmr_rmp_q; // [RL10]
	assign serial_a_pin_remap = sa_rmp_q; // [RL11]

	// -----------------------------------------------------------------
	// pin routing driven by the selects
	// -----------------------------------------------------------------

	scmr_pin_mux u_pin_mux
	(
		.ir_function_on(ir_on_q),
		.ir_polarity_sel(ir_pol_q),
		.ir_data_source_sel(ir_src_q),
		.ir_sw_data_bit(ir_dat_q),
		.ir_hw_data(ir_hw_data),
		.ir_data(ir_data),
		.timer_pin_remap(tmr_rmp_q),
		.tmr0_cap_p1(tmr0_cap_p1),
		.tmr0_cap_alt(tmr0_cap_alt),
		.tmr0_capture(tmr0_capture),
		.tmr0_pwm(tmr0_pwm),
		.tmr0_pwm_p1(tmr0_pwm_p1),
		.tmr0_pwm_alt(tmr0_pwm_alt),
		.serial_a_pin_remap(sa_rmp_q),
		.sa_rx_hi(sa_rx_hi),
		.sa_rx_lo(sa_rx_lo),
		.sa_rx(sa_rx),
		.sa_tx(sa_tx),
		.sa_tx_hi(sa_tx_hi),
		.sa_tx_lo(sa_tx_lo)
	);

endmodule // scmr_regs

// ==== scmr_pkg.sv ====
// Behaviour
// RL1: reserved bits read zero; reserved bits of infrared and remap registers ignore writes
// RL2: infrared control bit 0 switches infrared function on; cleared at reset
// RL3: infrared control bit 1 selects normal or inverted output polarity
// RL4: infrared control bit 2 selects amplitude or frequency shift keying
// RL5: infrared control bit 3 picks hardware data or the software data bit
// RL6: infrared control bit 4 holds the software infrared data value
// RL7: trigger register bits 15..12 pick internal or external trigger, timers 0..3
// RL8: trigger register bit 11 routes serial B to port 1 or alternative port
// RL9: trigger register bit 10 clocks the rtc from subsystem or auxiliary clock
// RL10: remap register bit 1 routes timer pins to port 1 or alternative port
// RL11: remap register bit 0 routes serial A to port 1 pins 4..7 or 0..3
// RL12: timer 0 capture only from selected pin set; pwm driven on both sets
// RL13: registers at offsets 02h, 04h, 06h, sixteen bits, reset 0000h; the code decodes them at byte addresses 08h, 10h, 18h
// RL14: word and byte writes accepted; a byte write leaves the other byte alone
package scmr_pkg;

	// -----------------------------------------------------------------
	// register indices and byte addresses
	// -----------------------------------------------------------------
	localparam logic [7:0] IDX_IR = 8'h02;
	localparam logic [7:0] IDX_TRG = 8'h04;
	localparam logic [7:0] IDX_RMP = 8'h06;
	localparam logic [7:0] ADDR_IR = {IDX_IR[5:0], 2'b00};
	localparam logic [7:0] ADDR_TRG = {IDX_TRG[5:0], 2'b00};
	localparam logic [7:0] ADDR_RMP = {IDX_RMP[5:0], 2'b00};

	// -----------------------------------------------------------------
	// reset values
	// -----------------------------------------------------------------
	localparam logic [15:0] RST_IR = 16'h0000;
	localparam logic [15:0] RST_TRG = 16'h0000;
	localparam logic [15:0] RST_RMP = 16'h0000;

	// -----------------------------------------------------------------
	// field positions
	// -----------------------------------------------------------------
	localparam int IR_ON_BIT = 0;
	localparam int IR_POL_BIT = 1;
	localparam int IR_MOD_BIT = 2;
	localparam int IR_SRC_BIT = 3;
	localparam int IR_DAT_BIT = 4;
	localparam int TRG_LSB = 12;
	localparam int TRG_CNT = 4;
	localparam int SB_RMP_BIT = 11;
	localparam int RTC_SEL_BIT = 10;
	localparam int SA_RMP_BIT = 0;
	localparam int TMR_RMP_BIT = 1;

endpackage

// ==== scmr_pin_mux.sv ====
`timescale 1ns/1ps
module scmr_pin_mux
(
	input wire logic ir_function_on,
	input wire logic ir_polarity_sel,
	input wire logic ir_data_source_sel,
	input wire logic ir_sw_data_bit,
	input wire logic ir_hw_data,
	output logic ir_data,
	input wire logic timer_pin_remap,
	input wire logic tmr0_cap_p1,
	input wire logic tmr0_cap_alt,
	output logic tmr0_capture,
	input wire logic tmr0_pwm,
	output logic tmr0_pwm_p1,
	output logic tmr0_pwm_alt,
	input wire logic serial_a_pin_remap,
	input wire logic sa_rx_hi,
	input wire logic sa_rx_lo,
	output logic sa_rx,
	input wire logic sa_tx,
	output logic sa_tx_hi,
	output logic sa_tx_lo
);

	// infrared data: source pick, then polarity, forced low when off
	always_comb
	begin
		ir_data = 1'b0;
		if (ir_function_on) // [RL2]
		begin
			ir_data = (ir_data_source_sel ? ir_sw_data_bit : ir_hw_data) // [RL5] [RL6]
				^ ir_polarity_sel; // [RL3]
		end
	end

	// capture only from the chosen pin set; pwm goes to both sets
	assign tmr0_capture = timer_pin_remap ? tmr0_cap_alt : tmr0_cap_p1; // [RL10] [RL12]
	assign tmr0_pwm_p1 = tmr0_pwm; // [RL12]
	assign tmr0_pwm_alt = tmr0_pwm; // [RL12]

	// serial A: unselected group idles high so a far receiver sees no start bit
	assign sa_rx = serial_a_pin_remap ? sa_rx_lo : sa_rx_hi; // [RL11]
	assign sa_tx_hi = serial_a_pin_remap ? 1'b1 : sa_tx; // [RL11]
	assign sa_tx_lo = serial_a_pin_remap ? sa_tx : 1'b1; // [RL11]

endmodule // scmr_pin_mux

// ==== scmr_regs_chk.sv ====
`timescale 1ns/1ps
module scmr_regs_chk
#(
	parameter int ADDR_W = 8
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic ir_function_on,
	input wire logic ir_polarity_sel,
	input wire logic ir_modulation_sel,
	input wire logic ir_data_source_sel,
	input wire logic ir_sw_data_bit,
	input wire logic ir_hw_data,
	input wire logic ir_data,
	input wire logic timer0_trigger_source,
	input wire logic timer1_trigger_source,
	input wire logic timer2_trigger_source,
	input wire logic timer3_trigger_source,
	input wire logic serial_b_pin_remap,
	input wire logic rtc_clock_source,
	input wire logic timer_pin_remap,
	input wire logic tmr0_cap_p1,
	input wire logic tmr0_cap_alt,
	input wire logic tmr0_capture
);
	// ----
	// helper terms
	// ----
	logic acc;
	logic hit_ir;
	logic hit_trg;
	logic hit_map;
	logic [4:0] ir_w;
	logic [5:0] trg_w;
	// decode kept apart from the design so a shared slip cannot hide
	assign acc = psel && penable;
	assign hit_ir = paddr == scmr_pkg::ADDR_IR;
	assign hit_trg = paddr == scmr_pkg::ADDR_TRG;
	assign hit_map = hit_ir || hit_trg || paddr == scmr_pkg::ADDR_RMP;
	assign ir_w = {ir_sw_data_bit, ir_data_source_sel, ir_modulation_sel, ir_polarity_sel,
		ir_function_on};
	assign trg_w = {timer0_trigger_source, timer1_trigger_source, timer2_trigger_source,
		timer3_trigger_source, serial_b_pin_remap, rtc_clock_source};

	// ----
	// properties
	// ----
	default clocking cb_chk @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_unmap; acc && !hit_map |-> pslverr && prdata == 32'h0; endproperty
	a_unmap: assert property (p_unmap)
		else $error("unmapped access not refused");
	property p_map; acc && hit_map |-> !pslverr; endproperty
	a_map: assert property (p_map)
		else $error("mapped access refused");
	property p_ir_rd; acc && !pwrite && hit_ir |-> prdata == {27'h0, ir_w}; endproperty
	a_ir_rd: assert property (p_ir_rd)
		else $error("infrared read mismatch");
	property p_trg_rd; acc && !pwrite && hit_trg |-> prdata == {16'h0, trg_w, 10'h0}; endproperty
	a_trg_rd: assert property (p_trg_rd)
		else $error("trigger read mismatch");
	property p_ir_wr; acc && pwrite && hit_ir && pstrb[0] |=> ir_w == $past(pwdata[4:0]); endproperty
	a_ir_wr: assert property (p_ir_wr)
		else $error("infrared write lost");
	// any cycle without a low-lane write must leave the infrared bits alone
	property p_ir_keep; !(acc && pwrite && hit_ir && pstrb[0]) |=> $stable(ir_w); endproperty
	a_ir_keep: assert property (p_ir_keep)
		else $error("infrared bits changed");
	property p_trg_wr; acc && pwrite && hit_trg && pstrb[1] |=> trg_w == $past(pwdata[15:10]); endproperty
	a_trg_wr: assert property (p_trg_wr)
		else $error("trigger write lost");
	property p_ir_out;
		ir_data == (ir_function_on && ((ir_data_source_sel ? ir_sw_data_bit : ir_hw_data)
			^ ir_polarity_sel));
	endproperty
	a_ir_out: assert property (p_ir_out)
		else $error("infrared data wrong");
	property p_cap; tmr0_capture == (timer_pin_remap ? tmr0_cap_alt : tmr0_cap_p1); endproperty
	a_cap: assert property (p_cap)
		else $error("capture source wrong");
	c_wr: cover property (acc && pwrite && hit_trg);
	c_rd: cover property (acc && !pwrite && hit_ir);
	c_err: cover property (acc && !hit_map);
endmodule // scmr_regs_chk

bind scmr_regs scmr_regs_chk #(.ADDR_W(ADDR_W)) scmr_regs_chk_inst (.*);

// ==== sys_config_mux_regs_tb_top.sv ====
`timescale 1ns/1ps
module sys_config_mux_regs_tb_top;
	// ----
	// signals
	// ----
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb;
	logic ir_function_on, ir_polarity_sel, ir_modulation_sel, ir_data_source_sel;
	logic ir_sw_data_bit, ir_hw_data, ir_data, timer0_trigger_source, timer1_trigger_source;
	logic timer2_trigger_source, timer3_trigger_source, serial_b_pin_remap, rtc_clock_source;
	logic timer_pin_remap, serial_a_pin_remap, tmr0_cap_p1, tmr0_cap_alt, tmr0_capture;
	logic tmr0_pwm, tmr0_pwm_p1, tmr0_pwm_alt, sa_rx_hi, sa_rx_lo, sa_rx, sa_tx;
	logic sa_tx_hi, sa_tx_lo;
	logic [7:0] adr [3] = '{scmr_pkg::ADDR_IR, scmr_pkg::ADDR_TRG, scmr_pkg::ADDR_RMP};
	logic [31:0] msk [3] = '{32'h1F, 32'hFC00, 32'h3};
	int bad_count;
	int total_checks;
	logic [4:0] ir_outs;
	logic [5:0] trg_outs;

	// register-driven outputs gathered in register bit order
	assign ir_outs = {ir_sw_data_bit, ir_data_source_sel, ir_modulation_sel, ir_polarity_sel,
		ir_function_on};
	assign trg_outs = {timer0_trigger_source, timer1_trigger_source, timer2_trigger_source,
		timer3_trigger_source, serial_b_pin_remap, rtc_clock_source};

	scmr_regs scmr_regs_inst (.*);

	// free-running 100 MHz clock
	initial
	begin
		pclk = 1'h0;
		forever #5 pclk = ~pclk;
	end

	// ----
	// helpers
	// ----
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		total_checks++;
		if (seen !== want)
		begin
			bad_count++;
			$display("BAD %0t seen %h want %h", $time, seen, want);
		end
	endtask

	// one apb transfer; waits on pready rather than assuming zero wait
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [31:0] x, input logic xe);
		int n;
		logic [31:0] r;
		logic e;
		n = 0;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'h1;
		// access ends at the first rising edge that sees pready high
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'h1 && n < 20);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		chk(pready, 32'h1);
		if (!w)
			chk(r, x);
		chk(e, xe);
	endtask

	// ----
	// scenarios
	// ----
	task automatic t_reset;
		// load every register so the reset has something to clear
		foreach (adr[k])
			xfer(1'h1, adr[k], 32'hFFFF_FFFF, 4'hF, 32'h0, 1'h0);
		@(posedge pclk);
		presetn <= 1'h0;
		@(posedge pclk);
		presetn <= 1'h1;
		foreach (adr[k])
			xfer(1'h0, adr[k], 32'h0, 4'h0, 32'h0, 1'h0);
		chk(ir_function_on, 32'h0);
		$display("reset test done");
	endtask

	// alternating patterns flip every stored bit both ways
	task automatic t_fields;
		logic [31:0] pat [3] = '{32'hFFFFFFFF, 32'h5555, 32'hAAAA};
		foreach (pat[p])
		begin
			foreach (adr[k])
			begin
				xfer(1'h1, adr[k], pat[p], 4'hF, 32'h0, 1'h0);
				xfer(1'h0, adr[k], 32'h0, 4'h0, pat[p] & msk[k], 1'h0);
			end
			chk(ir_outs, pat[p][4:0]);
			chk(trg_outs, pat[p][15:10]);
			chk({timer_pin_remap, serial_a_pin_remap}, pat[p][1:0]);
		end
		chk({timer_pin_remap, serial_a_pin_remap}, 32'h2);
		$display("field test done");
	endtask

	task automatic t_bytes;
		xfer(1'h1, adr[0], 32'h1F, 4'h1, 32'h0, 1'h0);
		xfer(1'h1, adr[0], 32'h0, 4'h2, 32'h0, 1'h0);
		xfer(1'h1, adr[0], 32'h0, 4'h0, 32'h0, 1'h0);
		xfer(1'h0, adr[0], 32'h0, 4'h0, 32'h1F, 1'h0);
		// clear what the field test left in the trigger register
		xfer(1'h1, adr[1], 32'h0, 4'hF, 32'h0, 1'h0);
		xfer(1'h1, adr[1], 32'hFFFF, 4'h1, 32'h0, 1'h0);
		xfer(1'h0, adr[1], 32'h0, 4'h0, 32'h0, 1'h0);
		xfer(1'h1, adr[1], 32'hFFFF, 4'h2, 32'h0, 1'h0);
		xfer(1'h0, adr[1], 32'h0, 4'h0, 32'hFC00, 1'h0);
		$display("byte test done");
	endtask

	task automatic t_unmapped;
		logic [7:0] hole [3] = '{8'h00, 8'h0C, 8'h1C};
		foreach (hole[k])
		begin
			xfer(1'h1, hole[k], 32'h0, 4'hF, 32'h0, 1'h1);
			xfer(1'h0, hole[k], 32'h0, 4'h0, 32'h0, 1'h1);
		end
		xfer(1'h0, adr[0], 32'h0, 4'h0, 32'h1F, 1'h0);
		$display("unmapped test done");
	endtask

	task automatic t_mux;
		for (int c = 0; c < 32; c++)
		begin
			xfer(1'h1, adr[0], 32'(c), 4'h1, 32'h0, 1'h0);
			for (int h = 0; h < 2; h++)
			begin
				@(posedge pclk);
				ir_hw_data <= h[0];
				@(negedge pclk);
				chk(ir_data, c[0] & ((c[3] ? c[4] : h[0]) ^ c[1]));
			end
		end
		for (int r = 0; r < 4; r++)
		begin
			xfer(1'h1, adr[2], 32'(r), 4'h1, 32'h0, 1'h0);
			for (int v = 0; v < 64; v++)
			begin
				@(posedge pclk);
				{tmr0_cap_p1, tmr0_cap_alt, tmr0_pwm, sa_rx_hi, sa_rx_lo, sa_tx} <= v[5:0];
				@(negedge pclk);
				chk({tmr0_capture, tmr0_pwm_p1, tmr0_pwm_alt}, {r[1] ? v[4] : v[5], v[3], v[3]});
				chk({sa_rx, sa_tx_hi, sa_tx_lo}, {r[0] ? v[1] : v[2], r[0] | v[0], !r[0] | v[0]});
			end
		end
		$display("mux test done");
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ----
	// main sequence
	// ----
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		{ir_hw_data, tmr0_cap_p1, tmr0_cap_alt, tmr0_pwm, sa_rx_hi, sa_rx_lo, sa_tx} = '0;
		repeat (12) @(posedge pclk);
		presetn <= 1'h1;
		t_reset;
		t_fields;
		t_bytes;
		t_unmapped;
		t_mux;
		complete_run;
	end

	// watchdog, far beyond the six hundred or so cycles the tests need
	initial
	begin
		#100us;
		bad_count++;
		complete_run;
	end
endmodule // sys_config_mux_regs_tb_top
